//--- hdl/adcsq_fifo.sv
// Result FIFO between the conversion core and the serial shifter.
// Assumes DEPTH is a power of two; both sides on sys_clk.
`timescale 1ns/1ps
module adcsq_fifo #(
  parameter int WIDTH = adcsq_pkg::FIFO_WIDTH,
  parameter int DEPTH = adcsq_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Word written
  output logic out_valid, // Word available
  input wire logic out_ready, // Word taken
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) ||
                    (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // No reset on storage; only written words are ever read
  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr_r[AW-1:0]] <= in_data;
  end
endmodule

//--- hdl/adcsq_pkg.sv
// Constants shared by the converter serial sequencer and its FIFO.
// Assumes a 40 MHz system clock that oversamples the serial pins.
package adcsq_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CTRL_WE_BIT = 15;
  localparam int CTRL_REPEAT_BIT = 14;
  localparam int CTRL_CH0_BIT = 13;
  localparam int CTRL_TSENSE_BIT = 5;
  localparam int CTRL_EXTREF_BIT = 2;
  localparam int CTRL_AVG_BIT = 1;
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_CH = 9;
  localparam logic [14:0] CTRL_RESET = 15'h0000;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [3:0] TAG_TEMP_RAW = 4'h8;
  localparam logic [3:0] TAG_TEMP_AVG = 4'h9;
  localparam logic [3:0] CH_TEMP = 4'h8;
  localparam logic [3:0] SYNC_RESET = 4'h9;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TEMP_CONV_NS = 100000;
  localparam int TEMP_CONV_CYC = TEMP_CONV_NS / CLK_PERIOD_NS;
  localparam int TEMP_CNT_W = 12;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_DONE} adcsq_frame_e;
endpackage

//--- hdl/adcsq_top.sv
// Serial port, control register and channel sequencer of an
// eight-input converter with a temperature channel.
// Assumes an analog core on conv_* / res_* and pins sampled here.
// Summary of operation
// - Averaging bit works only while temperature channel is selected.
// - Standby bit zero keeps normal mode; one moves to standby next.
// - Each frame sends four-bit channel tag then twelve-bit result.
// - Tag is input index, 1000 raw temperature, 1001 averaged.
// - Frame select fall enables data out with tag MSB.
// - Result LSB on 15th clock fall; released on 16th.
// - Temperature conversion raises busy at its frame start.
// - Busy frame runs fully; later frames ignored, ones out.
// - Temperature conversion finishes within 100 us, then busy drops.
// - Standby written in busy frame aborts and sleeps at 16th fall.
// - Channel selected in frame one converts in two, reads in three.
// - Several channels convert ascending, one a frame, then halt.
// - Completed or empty selection gives all ones.
// - Repeat mode wraps to the lowest selected channel forever.
// - A valid write ends repeat and applies new settings.
// - Standby write takes effect at following frame select rise.
// - Standby entry resets averaging; reads return all ones.
// - Standby exit: wake write, select write, convert, then result.
// - Power-down resets control register and averaging.
// - Data in shifts in on first 16 clock falls.
// - Bit 15 high updates the register; low discards the frame.
// - Bits 13 to 6 pick inputs 0 to 7, 14 repeat, 5 temp.
// - Short frame stops conversion, releases data out, keeps register.
`timescale 1ns/1ps
module adcsq_top (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic cs_n, // Frame select pin, active low
  input wire logic sclk, // Serial clock pin
  input wire logic din, // Serial data in pin
  input wire logic powerdown_reset_pin_n, // Power-down pin, active low
  output logic dout_o, // Serial data out level
  output logic dout_oe, // Serial data out enable
  output logic temp_conversion_busy, // Temperature conversion running
  output logic standby_o, // Core in standby
  output logic powerdown_o, // Core fully powered down
  output logic ref_power_o, // Reference supply enable
  output logic external_reference_select, // Reference choice
  output logic conv_start, // Pulse: sample and convert
  output logic [3:0] conv_channel, // Channel index, 8 is temp
  output logic conv_abort, // Pulse: drop running conversion
  input wire logic res_valid, // Core result offered
  input wire logic [11:0] res_data, // Core result
  output logic res_ready // Result taken
);
  // Channel mask: bit 8 is the temperature channel, above input seven
  function automatic logic [8:0] sel_of(input logic [15:0] w);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < adcsq_pkg::NUM_INPUTS; i++) begin
      m[i] = w[adcsq_pkg::CTRL_CH0_BIT - i];
    end
    m[8] = w[adcsq_pkg::CTRL_TSENSE_BIT];
    return m;
  endfunction

  function automatic logic [3:0] first_ch(input logic [8:0] m);
    logic [3:0] idx;
    idx = '0;
    for (int i = adcsq_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) idx = 4'(i);
    end
    return idx;
  endfunction

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic cs_d_r;
  logic sclk_d_r;
  adcsq_pkg::adcsq_frame_e state_r;
  adcsq_pkg::adcsq_frame_e state_nxt;
  logic [3:0] bit_cnt_r;
  logic [15:0] sh_out_r;
  logic [14:0] sh_in_r;
  logic ign_r;
  logic [14:0] ctrl_r;
  logic [8:0] seq_r;
  logic [8:0] seq_nxt;
  logic stby_r;
  logic stby_nxt;
  logic [adcsq_pkg::TEMP_CNT_W-1:0] tcnt_r;
  logic [adcsq_pkg::TEMP_CNT_W-1:0] tcnt_nxt;
  logic busyfr_r;
  logic cur_conv_r;
  logic pend_r;
  logic [3:0] pend_tag_r;
  logic signed [14:0] acc_r;
  logic acc_vld_r;

  logic cs_s, sclk_s, din_s, pd_act;
  logic cs_fall, cs_rise, sclk_fall;
  logic frame_end, short_abort, wr_ok, stby_abort;
  logic ign_now, conv_go, avg_on;
  logic [15:0] word_in, load_word, push_word;
  logic [8:0] rem_mask;
  logic [3:0] conv_idx, conv_tag;
  logic f_in_valid, f_in_ready, f_out_valid, f_pop;
  logic [15:0] f_out_data;
  logic avg_push;
  logic signed [15:0] acc_sum;
  logic signed [14:0] acc_nxt;
  logic [11:0] avg_out;

  assign cs_s = sync2_r[0];
  assign sclk_s = sync2_r[1];
  assign din_s = sync2_r[2];
  assign pd_act = ~sync2_r[3];
  assign cs_fall = cs_d_r & ~cs_s & ~pd_act & (state_r == adcsq_pkg::FR_IDLE);
  assign cs_rise = ~cs_d_r & cs_s;
  assign sclk_fall = sclk_d_r & ~sclk_s;

  assign short_abort = cs_rise & (state_r == adcsq_pkg::FR_SHIFT);
  assign frame_end = (state_r == adcsq_pkg::FR_SHIFT) & sclk_fall &
                     (bit_cnt_r == 4'(adcsq_pkg::FRAME_BITS - 1)) & ~cs_rise;
  assign word_in = {sh_in_r, din_s};
  assign wr_ok = frame_end & ~ign_r &
                 word_in[adcsq_pkg::CTRL_WE_BIT];
  assign stby_abort = wr_ok & busyfr_r &
                      word_in[adcsq_pkg::CTRL_STANDBY_BIT];

  assign ign_now = (tcnt_r != '0) & ~busyfr_r;
  assign conv_idx = first_ch(seq_r);
  assign conv_go = cs_fall & ~stby_r & ~ign_now & (|seq_r);
  assign rem_mask = seq_r & ~(9'h001 << conv_idx);
  assign avg_on = ctrl_r[adcsq_pkg::CTRL_AVG_BIT] &
                  ctrl_r[adcsq_pkg::CTRL_TSENSE_BIT];
  assign conv_tag = (conv_idx != adcsq_pkg::CH_TEMP) ? conv_idx :
                    avg_on ? adcsq_pkg::TAG_TEMP_AVG :
                    adcsq_pkg::TAG_TEMP_RAW;

  assign f_pop = cs_fall & ~stby_r & ~ign_now & f_out_valid;
  assign load_word = f_pop ? f_out_data : adcsq_pkg::ALL_ONES;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adcsq_pkg::FR_IDLE: begin
        if (cs_fall) state_nxt = adcsq_pkg::FR_SHIFT;
      end
      adcsq_pkg::FR_SHIFT: begin
        if (cs_rise) state_nxt = adcsq_pkg::FR_IDLE;
        else if (frame_end) state_nxt = adcsq_pkg::FR_DONE;
      end
      adcsq_pkg::FR_DONE: begin
        if (cs_rise) state_nxt = adcsq_pkg::FR_IDLE;
      end
      default: state_nxt = adcsq_pkg::FR_IDLE;
    endcase
    if (pd_act) state_nxt = adcsq_pkg::FR_IDLE;
  end

  always_comb begin
    seq_nxt = seq_r;
    if (pd_act) begin
      seq_nxt = '0;
    end else if (wr_ok) begin
      // Waking write selects nothing; the next write does
      seq_nxt = (stby_r | word_in[adcsq_pkg::CTRL_STANDBY_BIT]) ? '0 :
                sel_of(word_in);
    end else if (conv_go) begin
      seq_nxt = (rem_mask == '0 && ctrl_r[adcsq_pkg::CTRL_REPEAT_BIT]) ?
                sel_of({1'b0, ctrl_r}) : rem_mask;
    end
  end

  always_comb begin
    stby_nxt = stby_r;
    if (pd_act) stby_nxt = 1'b0;
    else if (stby_abort) stby_nxt = 1'b1;
    else if (cs_rise && state_r == adcsq_pkg::FR_DONE)
      stby_nxt = ctrl_r[adcsq_pkg::CTRL_STANDBY_BIT];
  end

  always_comb begin
    tcnt_nxt = tcnt_r;
    if (pd_act || stby_abort || (short_abort && busyfr_r))
      tcnt_nxt = '0;
    else if (conv_go && conv_idx == adcsq_pkg::CH_TEMP)
      tcnt_nxt = adcsq_pkg::TEMP_CNT_W'(adcsq_pkg::TEMP_CONV_CYC);
    else if (tcnt_r != '0)
      tcnt_nxt = tcnt_r - 1'b1;
  end

  // Running average kept at eight times scale to hold fractions
  assign f_in_valid = res_valid & pend_r;
  assign res_ready = pend_r ? f_in_ready : 1'b1;
  assign avg_push = f_in_valid & f_in_ready &
                    (pend_tag_r == adcsq_pkg::TAG_TEMP_AVG);
  assign acc_sum = 16'(acc_r) - 16'(acc_r >>> 3) +
                   16'(signed'(res_data));
  assign acc_nxt = acc_vld_r ? acc_sum[14:0] :
                   {signed'(res_data), 3'b000};
  assign avg_out = 12'(acc_nxt >>> 3);
  assign push_word = {pend_tag_r, (pend_tag_r == adcsq_pkg::TAG_TEMP_AVG) ?
                      avg_out : res_data};

  adcsq_fifo #(
    .WIDTH(adcsq_pkg::FIFO_WIDTH),
    .DEPTH(adcsq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(push_word),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= adcsq_pkg::SYNC_RESET;
      sync2_r <= adcsq_pkg::SYNC_RESET;
      cs_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {powerdown_reset_pin_n, din, sclk, cs_n};
      sync2_r <= sync1_r;
      cs_d_r <= cs_s;
      sclk_d_r <= sclk_s;
    end
  end

  // Serial shifter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= adcsq_pkg::FR_IDLE;
      bit_cnt_r <= '0;
      sh_out_r <= adcsq_pkg::ALL_ONES;
      sh_in_r <= '0;
      ign_r <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cs_fall) begin
        bit_cnt_r <= '0;
        sh_out_r <= (stby_r | ign_now) ? adcsq_pkg::ALL_ONES :
                    load_word;
        ign_r <= ign_now;
        dout_oe <= 1'b1;
      end else if (state_r == adcsq_pkg::FR_SHIFT && sclk_fall) begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
        sh_out_r <= {sh_out_r[14:0], 1'b1};
        sh_in_r <= word_in[14:0];
      end
      if (frame_end || cs_rise || pd_act) dout_oe <= 1'b0;
    end
  end

  // Control register and sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= adcsq_pkg::CTRL_RESET;
      seq_r <= '0;
      stby_r <= 1'b0;
      tcnt_r <= '0;
      temp_conversion_busy <= 1'b0;
      busyfr_r <= 1'b0;
      cur_conv_r <= 1'b0;
    end else begin
      if (pd_act) ctrl_r <= adcsq_pkg::CTRL_RESET;
      else if (wr_ok) ctrl_r <= word_in[14:0];
      seq_r <= seq_nxt;
      stby_r <= stby_nxt;
      tcnt_r <= tcnt_nxt;
      temp_conversion_busy <= tcnt_nxt != '0;
      if (cs_rise || pd_act) begin
        busyfr_r <= 1'b0;
        cur_conv_r <= 1'b0;
      end else if (conv_go) begin
        busyfr_r <= conv_idx == adcsq_pkg::CH_TEMP;
        cur_conv_r <= 1'b1;
      end
    end
  end

  // Core handshake and averaging
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      conv_start <= 1'b0;
      conv_channel <= '0;
      conv_abort <= 1'b0;
      pend_r <= 1'b0;
      pend_tag_r <= '0;
      acc_r <= '0;
      acc_vld_r <= 1'b0;
    end else begin
      conv_start <= conv_go;
      conv_abort <= (short_abort & cur_conv_r) | stby_abort;
      if (conv_go) conv_channel <= conv_idx;
      if (conv_go) begin
        pend_r <= 1'b1;
        pend_tag_r <= conv_tag;
      end else if ((short_abort & cur_conv_r) | stby_abort | pd_act) begin
        pend_r <= 1'b0;
      end else if (res_valid & res_ready) begin
        pend_r <= 1'b0;
      end
      if (pd_act || (stby_nxt && !stby_r) || !avg_on) begin
        acc_vld_r <= 1'b0;
      end else if (avg_push) begin
        acc_r <= acc_nxt;
        acc_vld_r <= 1'b1;
      end
    end
  end

  assign dout_o = sh_out_r[15];
  assign standby_o = stby_r;
  assign powerdown_o = pd_act;
  assign ref_power_o = ~pd_act;
  assign external_reference_select = ctrl_r[adcsq_pkg::CTRL_EXTREF_BIT];

  a_raw_temp_tag: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_go && conv_idx == adcsq_pkg::CH_TEMP && !avg_on
    |=> pend_tag_r == adcsq_pkg::TAG_TEMP_RAW)
    else $error("raw temperature tag wrong");
  a_standby_enter: assert property (@(posedge sys_clk) disable iff (!rstn)
    cs_rise && state_r == adcsq_pkg::FR_DONE && !pd_act &&
    ctrl_r[adcsq_pkg::CTRL_STANDBY_BIT] |=> standby_o)
    else $error("standby not entered at frame end");
  a_dout_release: assert property (@(posedge sys_clk) disable iff (!rstn)
    frame_end |=> !dout_oe)
    else $error("data out still driven after 16th fall");
  a_dout_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    cs_fall |=> dout_oe ##0 state_r == adcsq_pkg::FR_SHIFT)
    else $error("data out not enabled at frame start");
  a_busy_rise: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_go && conv_idx == adcsq_pkg::CH_TEMP && !pd_act
    |=> temp_conversion_busy [*8])
    else $error("busy not raised for temperature");
  a_busy_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
    temp_conversion_busy |-> tcnt_r != '0 &&
    tcnt_r <= adcsq_pkg::TEMP_CNT_W'(adcsq_pkg::TEMP_CONV_CYC))
    else $error("busy outlasts conversion time");
  a_ignored_ones: assert property (@(posedge sys_clk) disable iff (!rstn)
    cs_fall && ign_now |=> sh_out_r == adcsq_pkg::ALL_ONES && !conv_start)
    else $error("ignored frame not all ones");
  a_short_keep: assert property (@(posedge sys_clk) disable iff (!rstn)
    short_abort |=> $stable(ctrl_r) && !dout_oe)
    else $error("short frame changed register");
  a_write_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_ok && !pd_act |=> ctrl_r == $past(word_in[14:0]))
    else $error("control write not applied");
  a_standby_ones: assert property (@(posedge sys_clk) disable iff (!rstn)
    cs_fall && stby_r |=> sh_out_r == adcsq_pkg::ALL_ONES)
    else $error("standby read not all ones");
endmodule

//--- testbench/adcsq_host.sv
// Serial host model: frames cs_n, sclk and din, captures data out.
// Assumes a 40 MHz sys_clk; one sclk period is eight sys_clk cycles.
`timescale 1ns/1ps
module adcsq_host (
  input wire logic sys_clk, // System clock
  output logic cs_n, // Frame select, active low
  output logic sclk, // Serial clock, idles high
  output logic din, // Serial data to device
  input wire logic dout_o, // Device data out level
  input wire logic dout_oe // Device data out enable
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b1;
  end
  // A released line reads unknown, so a tri-stated bit never matches
  task automatic xfer(input logic [15:0] wr, input int nclk,
                      output logic [15:0] rd, output logic oe_end);
    rd = 16'hxxxx;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < nclk; i++) begin
      din <= wr[15-i];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rd[15-i] = dout_oe ? dout_o : 1'bx;
      @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b1;
    end
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    oe_end = dout_oe;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

//--- testbench/test_adcsq_top.sv
// Bench for the converter serial sequencer: host model on the pins,
// core model on the conversion handshake; FIFO reached through the top.
// Assumes the fixed 4000-cycle temperature conversion.
`timescale 1ns/1ps
module test_adcsq_top;
  localparam logic [15:0] WE = 16'h8000;
  localparam logic [15:0] ONES = adcsq_pkg::ALL_ONES;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic pd_n = 1'b1;
  logic cs_n, sclk, din, dout_o, dout_oe, busy, stby, pdo, refp, xref;
  logic conv_start, conv_abort, res_ready;
  logic res_valid = 1'b0;
  logic busy_d = 1'b0;
  logic abort_seen = 1'b0;
  logic [3:0] conv_channel;
  logic [3:0] pend_ch = 4'h0;
  logic [11:0] res_data = 12'h000;
  int dly = 0;
  int cyc = 0;
  int rise_c = 0;
  int fall_c = 0;
  int miscompares = 0;
  int n_checks = 0;

  adcsq_top dut (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n),
    .sclk(sclk), .din(din), .powerdown_reset_pin_n(pd_n),
    .dout_o(dout_o), .dout_oe(dout_oe), .temp_conversion_busy(busy),
    .standby_o(stby), .powerdown_o(pdo), .ref_power_o(refp),
    .external_reference_select(xref), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_abort(conv_abort),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
  adcsq_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout_o(dout_o), .dout_oe(dout_oe));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [11:0] res_of(input logic [3:0] ch);
    return {8'hA5, ch};
  endfunction
  function automatic logic [15:0] sel(input int n);
    return 16'h2000 >> n;
  endfunction

  // Core model: answers 20 cycles after each start, holds until taken
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    busy_d <= busy;
    if (busy && !busy_d) rise_c <= cyc;
    if (!busy && busy_d) fall_c <= cyc;
    if (conv_abort) abort_seen <= 1'b1;
    if (res_valid && res_ready) res_valid <= 1'b0;
    if (conv_start) begin
      pend_ch <= conv_channel;
      dly <= 20;
    end else if (dly > 0) begin
      dly <= dly - 1;
    end
    if (dly == 1 && !conv_start) begin
      res_valid <= 1'b1;
      res_data <= res_of(pend_ch);
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic s, input logic e);
    @(negedge sys_clk);
    check(what, {15'h0000, s}, {15'h0000, e});
  endtask
  task automatic fr(input logic [15:0] wr, input logic [15:0] exp);
    logic [15:0] rd;
    logic oe;
    host.xfer(wr, 16, rd, oe);
    check("frame word", rd, exp);
    check("oe after 16th", {15'h0000, oe}, 16'h0000);
  endtask

  task automatic t_single;
    fr(WE | sel(3), ONES);
    fr(16'h0000, ONES);
    fr(16'h0000, {4'h3, res_of(4'h3)});
    fr(sel(5), ONES);
    fr(16'h0000, ONES);
    fr(16'h0000, ONES);
    $display("t_single done");
  endtask
  task automatic t_scan;
    fr(WE | 16'h3FC0, ONES);
    fr(16'h0000, ONES);
    for (int i = 0; i < 8; i++) fr(16'h0000, {4'(i), res_of(4'(i))});
    fr(16'h0000, ONES);
    $display("t_scan done");
  endtask
  task automatic t_repeat;
    fr(WE | 16'h4000 | sel(2) | sel(5), ONES);
    fr(16'h0000, ONES);
    fr(16'h0000, {4'h2, res_of(4'h2)});
    fr(16'h0000, {4'h5, res_of(4'h5)});
    fr(WE | sel(4), {4'h2, res_of(4'h2)});
    fr(16'h0000, {4'h5, res_of(4'h5)});
    fr(16'h0000, {4'h4, res_of(4'h4)});
    fr(16'h0000, ONES);
    $display("t_repeat done");
  endtask
  task automatic t_temp;
    fr(WE | sel(7) | 16'h0022, ONES);
    fr(16'h0000, ONES);
    chk1("busy idle", busy, 1'b0);
    fr(16'h0000, {4'h7, res_of(4'h7)});
    chk1("busy up", busy, 1'b1);
    fr(WE | sel(0), ONES);
    for (int i = 0; i < 5000 && busy; i++) @(posedge sys_clk);
    // Acquisition gap before the next frame
    repeat (40) @(posedge sys_clk);
    check("busy length", 16'(fall_c - rise_c), 16'(adcsq_pkg::TEMP_CONV_CYC));
    fr(16'h0000, {4'h9, res_of(4'h8)});
    fr(16'h0000, ONES);
    $display("t_temp done");
  endtask
  task automatic t_standby;
    chk1("normal mode", stby, 1'b0);
    fr(WE | sel(1) | 16'h0001, ONES);
    chk1("standby on", stby, 1'b1);
    fr(16'h0000, ONES);
    fr(WE, ONES);
    chk1("standby off", stby, 1'b0);
    fr(WE | sel(1), ONES);
    fr(16'h0000, ONES);
    fr(16'h0000, {4'h1, res_of(4'h1)});
    $display("t_standby done");
  endtask
  task automatic t_abort;
    fr(WE | 16'h0020, ONES);
    abort_seen <= 1'b0;
    fr(WE | 16'h0001, ONES);
    chk1("busy aborted", busy, 1'b0);
    chk1("standby entered", stby, 1'b1);
    chk1("abort pulse", abort_seen, 1'b1);
    fr(WE, ONES);
    chk1("awake", stby, 1'b0);
    $display("t_abort done");
  endtask
  task automatic t_short;
    logic [15:0] rd;
    logic oe;
    host.xfer(WE | sel(6), 5, rd, oe);
    chk1("oe after short", dout_oe, 1'b0);
    fr(16'h0000, ONES);
    fr(16'h0000, ONES);
    $display("t_short done");
  endtask
  task automatic t_pd;
    fr(WE | sel(2) | 16'h0004, ONES);
    chk1("external_reference_select set", xref, 1'b1);
    @(posedge sys_clk);
    pd_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk1("powered down", pdo, 1'b1);
    chk1("ref off", refp, 1'b0);
    chk1("ctrl cleared", xref, 1'b0);
    @(posedge sys_clk);
    pd_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    fr(16'h0000, ONES);
    fr(16'h0000, ONES);
    $display("t_pd done");
  endtask
  task automatic t_fifo;
    // A result offered with nothing pending is taken and dropped
    @(posedge sys_clk);
    res_valid <= 1'b1;
    res_data <= 12'h123;
    chk1("stray result taken", res_ready, 1'b1);
    fr(16'h0000, ONES);
    // Results leave the FIFO in conversion order
    fr(WE | sel(0) | sel(4), ONES);
    fr(16'h0000, ONES);
    fr(16'h0000, {4'h0, res_of(4'h0)});
    fr(16'h0000, {4'h4, res_of(4'h4)});
    fr(16'h0000, ONES);
    $display("t_fifo done");
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_single;
    t_scan;
    t_repeat;
    t_temp;
    t_standby;
    t_abort;
    t_short;
    t_pd;
    t_fifo;
    tally_and_finish;
  end
  // About 11200 cycles expected; generous margin before giving up
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    $display("Error watchdog: run did not finish in time");
    tally_and_finish;
  end
endmodule
